/* nvm_status_pkg.sv */
// Constants, encodings and carrier types for the flash status block
package nvm_status_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_INT_FLAGS = 8'h14; // Ready and error flags
  localparam logic [7:0] OFS_STATUS    = 8'h18; // Controller status
  localparam logic [7:0] OFS_TARGET    = 8'h1C; // Command target offset
  localparam logic [7:0] OFS_LOCK      = 8'h20; // Region lock bits
  localparam logic [7:0] OFS_EVENT     = 8'h24; // Sticky events, read clears
  localparam logic [7:0] OFS_MASK      = 8'h28; // Event interrupt mask
  localparam logic [7:0] OFS_CTRL      = 8'h2C; // Sleep reduction select

  // Status register bit positions
  localparam int B_SECURITY = 8;
  localparam int B_FAULT    = 4;
  localparam int B_LOCKERR  = 3;
  localparam int B_BADCMD   = 2;
  localparam int B_LOADED   = 1;
  localparam int B_RED      = 0;

  // Interrupt flag register bit positions
  localparam int B_READY = 0;
  localparam int B_ERROR = 1;

  // Event and mask register layout
  localparam int EV_READY  = 0;
  localparam int EV_ERROR  = 1;
  localparam int EV_LOADED = 2;
  localparam int EV_W      = 3;

  // Control register field position
  localparam int SLEEP_SEL_LSB = 8;

  // Field widths and reset values
  localparam int          TARGET_W    = 22;
  localparam int          LOCK_N      = 16;
  localparam int          REGION_W    = 4;
  localparam logic [15:0] LOCK_ERASED = 16'hFFFF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sleep reduction select encoding
  typedef enum logic [1:0] {
    SLP_WAKE_ACCESS = 2'h0,
    SLP_WAKE_EXIT   = 2'h1,
    SLP_RESERVED    = 2'h2,
    SLP_DISABLED    = 2'h3
  } sleep_sel_t;

  // Event pulses and data from the flash command engine
  typedef struct packed {
    logic                fault;          // Program or erase error
    logic                lock_violation; // Program of a locked region
    logic                bad_command;    // Invalid command or key
    logic                pb_write;       // Word written to page buffer
    logic [TARGET_W-1:0] pb_addr;        // Half-word offset of that word
    logic                page_write;     // Page write command issued
    logic                pb_clear;       // Page buffer clear command
    logic                set_red;        // Set reduction command
    logic                clr_red;        // Clear reduction command
    logic                bus_access;     // Bus access to the array
    logic                sleep_enter;    // System enters sleep
    logic                sleep_exit;     // System leaves sleep
  } flash_evt_t;

  // Complete register state of the block
  typedef struct packed {
    logic                aw_full;    // Write address held
    logic [7:0]          aw_addr;    // Held write address
    logic                w_full;     // Write data held
    logic [31:0]         wdata;      // Held write data
    logic [3:0]          wstrb;      // Held byte strobes
    logic                bvalid;     // Write response pending
    logic [1:0]          bresp;      // Write response code
    logic                rvalid;     // Read data pending
    logic [31:0]         rdata;      // Read data
    logic [1:0]          rresp;      // Read response code
    logic                fault;      // Sticky flash fault
    logic                lockerr;    // Sticky locked-region write
    logic                badcmd;     // Sticky bad command
    logic                loaded;     // Page buffer loaded
    logic                red;        // Power reduction state
    logic                error_flag; // Sticky error interrupt flag
    logic                ready;      // Controller ready
    logic                security;   // Security protection active
    logic [TARGET_W-1:0] target;     // Command target offset
    logic [LOCK_N-1:0]   lock;       // Region lock bits, 0 = locked
    logic                lock_loaded;// Lock bits taken from user row
    logic [EV_W-1:0]     evt;        // Sticky interrupt events
    logic [EV_W-1:0]     mask;       // Interrupt mask
    sleep_sel_t          sleep_sel;  // Sleep reduction select
    logic [31:0]         eff;        // Effective byte address
    logic                irq;        // Interrupt output
  } state_t;

endpackage

/* nvm_status_address_lock.sv */
// Flash controller status, command address and region lock registers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Operation
// - Ready reads 0 busy, 1 accepting
// - Security status at status bit 8
// - Sticky flash fault bit 4, W1C
// - Sticky locked-region flag bit 3, W1C
// - Sticky bad-command flag bit 2, W1C
// - Page-buffer-loaded bit 1, cleared by commands/W1C
// - Reduction set by command or sleep
// - Reduction cleared by access, command, wake
// - 22-bit read-write target offset, reset zero
// - Page buffer write updates target offset
// - Effective address is start plus twice offset
// - Sixteen read-only lock bits, command changed
// - Lock bit 0 locked, 1 unlocked
// - Lock bits loaded from user row
// - Error interrupt flag on any error, W1C
// - Decode sleep reduction select values
module nvm_status_address_lock
  import nvm_status_pkg::*;
#(
  parameter int AXI_ADDR_W = 8              // Bus address width
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire flash_evt_t            flash_evt,
  input  wire logic                  flash_busy,
  input  wire logic                  security_in,
  input  wire logic                  lock_cmd_valid,
  input  wire logic                  lock_cmd_unlock,
  input  wire logic [REGION_W-1:0]   lock_cmd_region,
  input  wire logic [LOCK_N-1:0]     user_row_lock,
  input  wire logic [31:0]           section_start,
  output logic [TARGET_W-1:0]        command_target_offset,
  output logic [31:0]                effective_address,
  output logic [LOCK_N-1:0]          region_lock,
  output logic                       power_reduction_state,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  // The decoder looks at eight address bits
  if (AXI_ADDR_W < 8) begin : g_bad_width
    $error("AXI_ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  state_t      s;           // Registered state
  state_t      n;           // Next state
  logic [31:0] wmask;       // Byte strobes widened to bits
  logic [31:0] wbits;       // Write data under the strobes
  logic [7:0]  waddr;       // Aligned held write address
  logic [7:0]  raddr;       // Aligned read address
  logic        wr_go;       // Write performed this cycle
  logic        rd_go;       // Read taken this cycle
  logic        any_err;     // Any of the three error events
  logic        red_set;     // Reduction entry request
  logic        red_clr;     // Reduction exit request
  logic        auto_enter;  // Sleep entry triggers reduction
  logic [31:0] rv;          // Read value before registering
  logic [1:0]  rr;          // Read response before registering

  // Whether an aligned address holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {OFS_INT_FLAGS, OFS_STATUS, OFS_TARGET, OFS_LOCK,
                     OFS_EVENT, OFS_MASK, OFS_CTRL};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte strobe expansion

  // One lane enable per byte of write data
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{s.wstrb[i]}};
  end

  assign wbits = s.wdata & wmask;
  assign waddr = {s.aw_addr[7:2], 2'h0};
  assign raddr = {araddr[7:2], 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs

  // Ready only while clocked, so no handshake is taken while frozen
  assign awready = ce && !s.aw_full;
  assign wready  = ce && !s.w_full;
  assign arready = ce && !s.rvalid;
  assign wr_go   = s.aw_full && s.w_full && !s.bvalid;
  assign rd_go   = arvalid && arready;

  // Registered data outputs
  assign bvalid                = s.bvalid;
  assign bresp                 = s.bresp;
  assign rvalid                = s.rvalid;
  assign rdata                 = s.rdata;
  assign rresp                 = s.rresp;
  assign command_target_offset = s.target;
  assign effective_address     = s.eff;
  assign region_lock           = s.lock;
  assign power_reduction_state = s.red;
  assign irq                   = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Read value mux

  // Unlisted bits stay zero; unmapped words answer with an error
  always_comb begin
    rv = 32'h0000_0000;
    rr = RESP_OKAY;
    case (raddr)
      OFS_INT_FLAGS: begin
        rv[B_READY] = s.ready;
        rv[B_ERROR] = s.error_flag;
      end
      OFS_STATUS: begin
        rv[B_SECURITY] = s.security;
        rv[B_FAULT]    = s.fault;
        rv[B_LOCKERR]  = s.lockerr;
        rv[B_BADCMD]   = s.badcmd;
        rv[B_LOADED]   = s.loaded;
        rv[B_RED]      = s.red;
      end
      OFS_TARGET: rv[TARGET_W-1:0] = s.target;
      OFS_LOCK:   rv[LOCK_N-1:0] = s.lock;
      OFS_EVENT:  rv[EV_W-1:0] = s.evt;
      OFS_MASK:   rv[EV_W-1:0] = s.mask;
      OFS_CTRL:   rv[SLEEP_SEL_LSB +: 2] = s.sleep_sel;
      default:    rr = RESP_SLVERR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decoding

  assign any_err = flash_evt.fault || flash_evt.lock_violation ||
                   flash_evt.bad_command;

  // Only the two wake settings enter reduction on sleep
  always_comb begin
    case (s.sleep_sel)
      SLP_WAKE_ACCESS, SLP_WAKE_EXIT: auto_enter = 1'b1;
      default:         auto_enter = 1'b0;
    endcase
  end

  assign red_set = flash_evt.set_red ||
                   (flash_evt.sleep_enter && auto_enter);
  assign red_clr = flash_evt.bus_access || flash_evt.clr_red ||
                   (flash_evt.sleep_exit &&
                    s.sleep_sel == SLP_WAKE_EXIT);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus channels, register writes and hardware events in one place
  always_comb begin
    n = s;
    // Write address and data are caught in either order
    if (awvalid && awready) begin
      n.aw_full = 1'b1;
      n.aw_addr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      n.w_full = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    // Perform the write once both halves are held
    if (wr_go) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = is_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // Read answer is registered one cycle after the address
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rdata  = rv;
      n.rresp  = rr;
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Sticky error flags: a new event beats a same-cycle clear
    n.fault   = (s.fault && !(wr_go && waddr == OFS_STATUS &&
                wbits[B_FAULT])) || flash_evt.fault;
    n.lockerr = (s.lockerr && !(wr_go && waddr == OFS_STATUS &&
                wbits[B_LOCKERR])) || flash_evt.lock_violation;
    n.badcmd  = (s.badcmd && !(wr_go && waddr == OFS_STATUS &&
                wbits[B_BADCMD])) || flash_evt.bad_command;
    n.loaded  = (s.loaded && !flash_evt.page_write &&
                !flash_evt.pb_clear && !(wr_go &&
                waddr == OFS_STATUS && wbits[B_LOADED])) ||
                flash_evt.pb_write;
    n.error_flag = (s.error_flag && !(wr_go &&
                   waddr == OFS_INT_FLAGS && wbits[B_ERROR])) ||
                   any_err;

    // Entry wins when both requests arrive together
    if (red_set) begin
      n.red = 1'b1;
    end else if (red_clr) begin
      n.red = 1'b0;
    end

    // Live levels from the flash engine
    n.ready    = !flash_busy;
    n.security = security_in;

    // Target offset: bytewise write, page buffer load has priority
    if (wr_go && waddr == OFS_TARGET) begin
      n.target = (s.target & ~wmask[TARGET_W-1:0]) |
                 wbits[TARGET_W-1:0];
    end
    if (flash_evt.pb_write) begin
      n.target = flash_evt.pb_addr;
    end
    n.eff = section_start + {9'h000, n.target, 1'b0};

    // Lock bits: user row first, then only lock commands change them
    if (!s.lock_loaded) begin
      n.lock        = user_row_lock;
      n.lock_loaded = 1'b1;
    end else if (lock_cmd_valid) begin
      n.lock[lock_cmd_region] = lock_cmd_unlock;
    end

    // Interrupt events: set beats read-clear; no ready edge out of reset
    n.evt = s.evt & ~{EV_W{rd_go && raddr == OFS_EVENT}};
    n.evt[EV_READY]  = n.evt[EV_READY] || (!s.ready && !flash_busy &&
                       s.lock_loaded);
    n.evt[EV_ERROR]  = n.evt[EV_ERROR] || any_err;
    n.evt[EV_LOADED] = n.evt[EV_LOADED] || flash_evt.pb_write;
    if (wr_go && waddr == OFS_MASK && s.wstrb[0]) begin
      n.mask = s.wdata[EV_W-1:0];
    end
    if (wr_go && waddr == OFS_CTRL && s.wstrb[1]) begin
      n.sleep_sel = sleep_sel_t'(s.wdata[SLEEP_SEL_LSB +: 2]);
    end
    n.irq = |(n.evt & n.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Clock enable low freezes every flip-flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s           <= '0;
      s.lock      <= LOCK_ERASED;
      s.sleep_sel <= SLP_WAKE_ACCESS;
    end else if (ce) begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Both write halves held and no response outstanding
  sequence s_write_ready;
    s.aw_full && s.w_full && !s.bvalid;
  endsequence

  // A page buffer load followed by a clearing command
  sequence s_load_then_clear;
    (ce && flash_evt.pb_write) ##1
    (ce && flash_evt.pb_clear && !flash_evt.pb_write);
  endsequence

  property p_ready;
    @(posedge sys_clk) disable iff (!reset_n)
      ce |=> s.ready == !$past(flash_busy);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready does not follow busy");

  property p_security;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && security_in |=> s.security;
  endproperty
  a_security: assert property (p_security)
    else $error("security bit not shown");

  property p_fault_sticky;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && flash_evt.fault |=> s.fault && s.error_flag;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault event lost");

  property p_lockerr;
    @(posedge sys_clk) disable iff (!reset_n)
      s.lockerr && !(ce && wr_go && waddr == OFS_STATUS &&
      wbits[B_LOCKERR]) |=> s.lockerr;
  endproperty
  a_lockerr: assert property (p_lockerr)
    else $error("locked region flag dropped without clear");

  property p_badcmd;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && flash_evt.bad_command |=> s.badcmd;
  endproperty
  a_badcmd: assert property (p_badcmd)
    else $error("bad command flag not set");

  property p_loaded;
    @(posedge sys_clk) disable iff (!reset_n)
      s_load_then_clear |=> !s.loaded;
  endproperty
  a_loaded: assert property (p_loaded)
    else $error("loaded flag not cleared by buffer clear");

  property p_red_sleep;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && flash_evt.sleep_enter && !flash_evt.set_red &&
      s.sleep_sel == SLP_DISABLED && !s.red |=> !s.red;
  endproperty
  a_red_sleep: assert property (p_red_sleep)
    else $error("reduction entered while disabled");

  property p_red_exit;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && flash_evt.bus_access && !red_set |=> !s.red;
  endproperty
  a_red_exit: assert property (p_red_exit)
    else $error("reduction not left on access");

  property p_target;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && flash_evt.pb_write |=> s.target == $past(flash_evt.pb_addr);
  endproperty
  a_target: assert property (p_target)
    else $error("target not updated by page buffer write");

  property p_eff;
    @(posedge sys_clk) disable iff (!reset_n)
      ce |=> s.eff == $past(section_start) + {9'h000, s.target, 1'b0};
  endproperty
  a_eff: assert property (p_eff)
    else $error("effective address wrong");

  property p_lock_load;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && !s.lock_loaded |=> s.lock == $past(user_row_lock);
  endproperty
  a_lock_load: assert property (p_lock_load)
    else $error("lock bits not loaded from user row");

  property p_lock_stable;
    @(posedge sys_clk) disable iff (!reset_n)
      ce && s.lock_loaded && !lock_cmd_valid |=> $stable(s.lock);
  endproperty
  a_lock_stable: assert property (p_lock_stable)
    else $error("lock bits changed without command");

  property p_bresp;
    @(posedge sys_clk) disable iff (!reset_n)
      (ce and s_write_ready) |=> s.bvalid ##0 !s.aw_full;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");

  property p_reserved;
    @(posedge sys_clk) disable iff (!reset_n)
      rd_go && raddr == OFS_TARGET |=> s.rdata[31:TARGET_W] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("unused target bits read nonzero");

endmodule

/* nvm_flash_model.sv */
// Behavioural flash engine that feeds events into the status block
`timescale 1ns/100ps
module nvm_flash_model
  import nvm_status_pkg::*;
(
  input  wire logic  sys_clk,
  output flash_evt_t flash_evt,
  output logic       flash_busy,
  output logic       security_in,
  output logic       lock_cmd_valid,
  output logic       lock_cmd_unlock,
  output logic [3:0] lock_cmd_region,
  output logic [15:0] user_row_lock,
  output logic [31:0] section_start
);
  // Idle levels; user row holds a mixed lock pattern, security on
  initial begin
    flash_evt       = '0;
    flash_busy      = 1'b0;
    security_in     = 1'b1;
    lock_cmd_valid  = 1'b0;
    lock_cmd_unlock = 1'b0;
    lock_cmd_region = 4'h0;
    user_row_lock   = 16'hA5F0;
    section_start   = 32'h0040_0000;
  end
  // One-cycle event pulse after an optional delay (slow engine)
  task automatic pulse(input flash_evt_t e, input int gap);
    repeat (gap) @(posedge sys_clk);
    flash_evt <= e;
    @(posedge sys_clk);
    flash_evt <= '0;
  endtask
  // Two back-to-back event pulses on consecutive edges
  task automatic pulse2(input flash_evt_t a, input flash_evt_t b);
    flash_evt <= a;
    @(posedge sys_clk);
    flash_evt <= b;
    @(posedge sys_clk);
    flash_evt <= '0;
  endtask
  // Lock or unlock command for one region
  task automatic lock(input logic [3:0] r, input logic u);
    lock_cmd_valid  <= 1'b1;
    lock_cmd_region <= r;
    lock_cmd_unlock <= u;
    @(posedge sys_clk);
    lock_cmd_valid  <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Program or erase in progress level
  task automatic busy(input logic b);
    flash_busy <= b;
  endtask
endmodule

/* nvm_status_address_lock_tb.sv */
// Self-checking bench for the flash status block
`timescale 1ns/100ps
`define CHK(n,e,g) begin checks++; if ((g)!==(e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module nvm_status_address_lock_tb;
  import nvm_status_pkg::*;
  logic sys_clk, reset_n, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, pr, lcv, lcu, fb, sec;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ss, eff, d;
  logic [3:0] wstrb, lcr;
  logic [1:0] bresp, rresp, br, rr;
  logic [21:0] tgt;
  logic [15:0] url, rl;
  flash_evt_t fe, e;
  int mismatches, checks, cyc;
  ////////////////////////////////////////////////////////////////////////////
  nvm_flash_model fm (.sys_clk(sys_clk), .flash_evt(fe), .flash_busy(fb),
    .security_in(sec), .lock_cmd_valid(lcv), .lock_cmd_unlock(lcu),
    .lock_cmd_region(lcr), .user_row_lock(url), .section_start(ss));
  nvm_status_address_lock DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .flash_evt(fe), .flash_busy(fb),
    .security_in(sec), .lock_cmd_valid(lcv), .lock_cmd_unlock(lcu),
    .lock_cmd_region(lcr), .user_row_lock(url), .section_start(ss),
    .command_target_offset(tgt), .effective_address(eff),
    .region_lock(rl), .power_reduction_state(pr), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // AXI write: sample handshakes mid-cycle, release right after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge sys_clk);
    awaddr <= a; wdata <= v; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; tb = 1'b0;
    while (!tb) begin
      @(negedge sys_clk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; br = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  // AXI read
  task automatic rd(input logic [7:0] a);
    logic t, v;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; v = 1'b0;
    while (!v) begin
      @(negedge sys_clk);
      t = arvalid & arready; v = rvalid; d = rdata; rr = rresp;
      @(posedge sys_clk);
      if (t) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, ready, security, lock load, target width
  task automatic t_reset;
    rd(OFS_INT_FLAGS); `CHK("ready", 1'b1, d[0])
    rd(OFS_STATUS); `CHK("security", 1'b1, d[8])
    rd(OFS_TARGET); `CHK("target_rst", 32'h0, d)
    rd(OFS_LOCK); `CHK("lock_load", 32'h0000A5F0, d)
    wr(OFS_TARGET, 32'hFFFFFFFF); rd(OFS_TARGET);
    `CHK("target_w", 32'h003FFFFF, d)
    fm.busy(1'b1); rd(OFS_INT_FLAGS); `CHK("busy", 1'b0, d[0])
    fm.busy(1'b0);
  endtask
  // Each error flag sets, raises error flag, clears by writing one
  task automatic t_errors;
    for (int k = 0; k < 3; k++) begin
      e = '0; e.fault = k == 0; e.lock_violation = k == 1;
      e.bad_command = k == 2; fm.pulse(e, k);
      rd(OFS_STATUS); `CHK("err_set", 1'b1, d[4-k])
      rd(OFS_INT_FLAGS); `CHK("err_irqf", 1'b1, d[1])
      wr(OFS_STATUS, 32'h1 << (4-k)); wr(OFS_INT_FLAGS, 32'h2);
      rd(OFS_STATUS); `CHK("err_clr", 32'h100, d)
      rd(OFS_INT_FLAGS); `CHK("irqf_clr", 1'b0, d[1])
    end
  endtask
  // Page buffer load, target update, effective address
  task automatic t_page;
    flash_evt_t c;
    e = '0; e.pb_write = 1'b1; e.pb_addr = 22'h000200; fm.pulse(e, 0);
    rd(OFS_STATUS); `CHK("loaded", 1'b1, d[1])
    `CHK("tgt", 22'h000200, tgt)
    `CHK("eff", 32'h00400400, eff)
    e = '0; e.page_write = 1'b1; fm.pulse(e, 0);
    rd(OFS_STATUS); `CHK("ld_pw", 1'b0, d[1])
    e = '0; e.pb_write = 1'b1; e.pb_addr = 22'h000300; c = '0;
    c.pb_clear = 1'b1; fm.pulse2(e, c);
    rd(OFS_STATUS); `CHK("ld_clr", 1'b0, d[1])
    `CHK("tgt2", 22'h000300, tgt)
  endtask
  // Reduction by command and by sleep for each select value
  task automatic t_prm;
    e = '0; e.set_red = 1'b1; fm.pulse(e, 0); rd(OFS_STATUS);
    `CHK("red_cmd", 1'b1, d[0])
    e = '0; e.bus_access = 1'b1; fm.pulse(e, 0); repeat (2) @(posedge sys_clk);
    `CHK("red_acc", 1'b0, pr)
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, s << 8); e = '0; e.sleep_enter = 1'b1; fm.pulse(e, 0);
      @(posedge sys_clk); `CHK("red_slp", s < 2, pr)
      e = '0; e.sleep_exit = 1'b1; fm.pulse(e, 0); @(posedge sys_clk);
      `CHK("red_exit", s == 0, pr)
      e = '0; e.clr_red = 1'b1; fm.pulse(e, 0);
    end
  endtask
  // Lock bits read-only, changed by commands only
  task automatic t_lock;
    wr(OFS_LOCK, 32'h0); rd(OFS_LOCK); `CHK("lock_ro", 32'hA5F0, d)
    fm.lock(4'h4, 1'b0); fm.lock(4'h0, 1'b1); rd(OFS_LOCK);
    `CHK("lock_cmd", 32'hA5E1, d)
    `CHK("lock_port", 16'hA5E1, rl)
  endtask
  // Interrupt raise, mask, read-clear; unmapped address
  task automatic t_irq;
    rd(OFS_EVENT); wr(OFS_MASK, 32'h0); e = '0; e.fault = 1'b1;
    fm.pulse(e, 0); @(posedge sys_clk); `CHK("irq_mask", 1'b0, irq)
    wr(OFS_MASK, 32'h2); @(posedge sys_clk); `CHK("irq_on", 1'b1, irq)
    rd(OFS_EVENT); `CHK("evt", 1'b1, d[1])
    @(posedge sys_clk); `CHK("irq_off", 1'b0, irq)
    rd(8'h3C); `CHK("unmap", RESP_SLVERR, rr)
    wr(8'h3C, 32'h1); `CHK("unmap_w", RESP_SLVERR, br)
  endtask
  // Clock enable low freezes state and ignores events
  task automatic t_ce;
    ce <= 1'b0; e = '0; e.set_red = 1'b1; fm.pulse(e, 0);
    @(posedge sys_clk); `CHK("ce_frz", 1'b0, pr)
    ce <= 1'b1;
  endtask
  // Closing report
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1; mismatches = 0; checks = 0; cyc = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset; t_errors; t_page; t_prm; t_lock; t_irq; t_ce;
    summarize();
  end
endmodule
